//--- src/cpu_regs_defines.vh
`ifndef CPU_REGS_DEFINES_VH
`define CPU_REGS_DEFINES_VH
// flag register bit positions
`define FLAG_IMASK      7
`define FLAG_USER1      6
`define FLAG_HALF       5
`define FLAG_USER0      4
`define FLAG_NEG        3
`define FLAG_ZERO       2
`define FLAG_OVF        1
`define FLAG_CARRY      0
// reset vector address and stack pointer index
`define RESET_VEC_ADDR  16'h0000
`define SP_INDEX        3'h7
// flag update source select
`define FSRC_HOLD       3'h0
`define FSRC_ALU_BYTE   3'h1
`define FSRC_ALU_WORD   3'h2
`define FSRC_LOAD       3'h3
`define FSRC_AND        3'h4
`define FSRC_OR         3'h5
`define FSRC_XOR        3'h6
`define FSRC_POP        3'h7
// branch conditions
`define CC_ALWAYS       4'h0
`define CC_NEVER        4'h1
`define CC_HI           4'h2
`define CC_LS           4'h3
`define CC_CC           4'h4
`define CC_CS           4'h5
`define CC_NE           4'h6
`define CC_EQ           4'h7
`define CC_VC           4'h8
`define CC_VS           4'h9
`define CC_PL           4'hA
`define CC_MI           4'hB
`define CC_GE           4'hC
`define CC_LT           4'hD
`define CC_GT           4'hE
`define CC_LE           4'hF
`endif

//--- src/flag_eval.v
`timescale 1ns/100ps
`include "cpu_regs_defines.vh"
// derives result flags and branch decision from flag values
module flag_eval (
  // result of byte or word operation
  input  wire [15:0] result,
  input  wire        word_op,
  input  wire        half_carry,
  input  wire        carry,
  input  wire        overflow,
  input  wire        half_en,
  // current flags and branch condition
  input  wire [7:0]  flags,
  input  wire [3:0]  cond,
  // outputs
  output wire [7:0]  alu_flags,
  output reg         take_branch
);
  wire n;
  wire z;
  wire c;
  wire v;

  // sign and zero taken from the active width
  assign n = word_op ? result[15] : result[7];
  assign z = word_op ? (result == 16'h0000) : (result[7:0] == 8'h00);
  assign alu_flags = {flags[`FLAG_IMASK], flags[`FLAG_USER1],
                      half_en ? half_carry : flags[`FLAG_HALF],
                      flags[`FLAG_USER0], n, z, overflow, carry};

  // branch test uses only negative, zero, overflow and carry
  assign c = flags[`FLAG_CARRY];
  assign v = flags[`FLAG_OVF];
  always @* begin
    case (cond)
      `CC_ALWAYS: take_branch = 1'b1;
      `CC_NEVER:  take_branch = 1'b0;
      `CC_HI:     take_branch = ~(c | flags[`FLAG_ZERO]);
      `CC_LS:     take_branch = c | flags[`FLAG_ZERO];
      `CC_CC:     take_branch = ~c;
      `CC_CS:     take_branch = c;
      `CC_NE:     take_branch = ~flags[`FLAG_ZERO];
      `CC_EQ:     take_branch = flags[`FLAG_ZERO];
      `CC_VC:     take_branch = ~v;
      `CC_VS:     take_branch = v;
      `CC_PL:     take_branch = ~flags[`FLAG_NEG];
      `CC_MI:     take_branch = flags[`FLAG_NEG];
      `CC_GE:     take_branch = ~(flags[`FLAG_NEG] ^ v);
      `CC_LT:     take_branch = flags[`FLAG_NEG] ^ v;
      `CC_GT:     take_branch = ~(flags[`FLAG_ZERO] | (flags[`FLAG_NEG] ^ v));
      `CC_LE:     take_branch = flags[`FLAG_ZERO] | (flags[`FLAG_NEG] ^ v);
      default:    take_branch = 1'b0;
    endcase
  end
endmodule

//--- src/cpu_register_file.v
`timescale 1ns/100ps
`include "cpu_regs_defines.vh"
module cpu_register_file (
  // clock, reset, enable
  input  wire        MCLK,
  input  wire        RST_B,
  input  wire        CLK_EN,
  // reset vector fetch
  output wire [15:0] VEC_ADDR,
  input  wire        VEC_VALID,
  input  wire [15:0] VEC_DATA,
  output wire        RESET_BUSY,
  // register read ports
  input  wire [2:0]  RD_A_SEL,
  input  wire [2:0]  RD_B_SEL,
  output wire [15:0] RD_A_WORD,
  output wire [15:0] RD_B_WORD,
  output wire [7:0]  RD_A_UPPER,
  output wire [7:0]  RD_A_LOWER,
  // register write port
  input  wire [2:0]  WR_SEL,
  input  wire        WR_UPPER_EN,
  input  wire        WR_LOWER_EN,
  input  wire [15:0] WR_DATA,
  // stack pointer adjust
  input  wire        SP_DEC,
  input  wire        SP_INC,
  output wire [15:0] STACK_POINTER,
  // address from register plus offset
  input  wire [2:0]  ADDR_SEL,
  input  wire [15:0] ADDR_DISP,
  input  wire        ADDR_WORD,
  output reg  [15:0] MEM_ADDR,
  // instruction address control
  input  wire        IA_LOAD,
  input  wire [15:0] IA_DATA,
  input  wire        IA_ADVANCE,
  output wire [15:0] INSTRUCTION_ADDR,
  // flag register update
  input  wire [2:0]  FLAG_SRC,
  input  wire [7:0]  FLAG_DATA,
  input  wire [15:0] ALU_RESULT,
  input  wire        ALU_HALF,
  input  wire        ALU_HALF_EN,
  input  wire        ALU_CARRY,
  input  wire        ALU_OVF,
  input  wire        EXC_START,
  output wire [7:0]  FLAG_REGISTER,
  output wire [15:0] FLAG_PUSH_WORD,
  output wire        IRQ_MASKED,
  // branch and bit helpers
  input  wire [3:0]  BRANCH_COND,
  output wire        BRANCH_TAKE,
  input  wire [7:0]  BIT_OPERAND,
  input  wire [2:0]  BIT_SEL,
  output wire        BIT_VALUE,
  output wire [7:0]  DAA_ADJUST,
  output wire [7:0]  DAS_ADJUST
);

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencing states
  localparam [2:0] ST_VEC  = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_IDLE = 3'b100;

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [15:0] ia_reg;
  reg  [15:0] ia_next;
  reg  [7:0]  flags_reg;
  reg  [7:0]  flags_next;
  reg  [7:0]  upper_mem [0:7];
  reg  [7:0]  lower_mem [0:7];
  wire [7:0]  alu_flags;
  wire [15:0] sp_word;
  reg  [15:0] raw_addr;

  ////////////////////////////////////////////////////////////////////////////
  // general registers, no reset value
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gp_word_regs
      always @(posedge MCLK) begin
        if (CLK_EN) begin
          if (WR_SEL == g && WR_UPPER_EN)
            upper_mem[g] <= WR_DATA[15:8];
          else if (g == 7 && (SP_DEC || SP_INC))
            upper_mem[g] <= SP_DEC ? sp_word[15:8] - ((sp_word[7:0] < 8'h02) ? 8'h01 : 8'h00)
                                   : sp_word[15:8] + ((sp_word[7:0] > 8'hFD) ? 8'h01 : 8'h00);
          if (WR_SEL == g && WR_LOWER_EN)
            lower_mem[g] <= WR_DATA[7:0];
          else if (g == 7 && (SP_DEC || SP_INC))
            lower_mem[g] <= SP_DEC ? sp_word[7:0] - 8'h02 : sp_word[7:0] + 8'h02;
        end
      end
    end
  endgenerate

  // read ports
  assign RD_A_WORD     = {upper_mem[RD_A_SEL], lower_mem[RD_A_SEL]};
  assign RD_B_WORD     = {upper_mem[RD_B_SEL], lower_mem[RD_B_SEL]};
  assign RD_A_UPPER    = upper_mem[RD_A_SEL];
  assign RD_A_LOWER    = lower_mem[RD_A_SEL];
  assign sp_word       = {upper_mem[`SP_INDEX], lower_mem[`SP_INDEX]};
  assign STACK_POINTER = sp_word;

  ////////////////////////////////////////////////////////////////////////////
  // memory address from full word register, 16-bit space
  always @* begin
    raw_addr = {upper_mem[ADDR_SEL], lower_mem[ADDR_SEL]} + ADDR_DISP;
    MEM_ADDR = ADDR_WORD ? {raw_addr[15:1], 1'b0} : raw_addr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencing and instruction address
  assign VEC_ADDR         = `RESET_VEC_ADDR;
  assign RESET_BUSY       = state_reg != ST_RUN;
  assign INSTRUCTION_ADDR = {ia_reg[15:1], 1'b0};

  always @* begin
    state_next = state_reg;
    ia_next    = ia_reg;
    case (state_reg)
      ST_VEC: begin
        if (VEC_VALID) begin
          ia_next    = {VEC_DATA[15:1], 1'b0};
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (IA_LOAD)
          ia_next = {IA_DATA[15:1], 1'b0};
        else if (IA_ADVANCE)
          ia_next = {ia_reg[15:1], 1'b0} + 16'h0002;
      end
      ST_IDLE: state_next = ST_VEC;
      default: state_next = ST_VEC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag register next value
  always @* begin
    case (FLAG_SRC)
      `FSRC_ALU_BYTE: flags_next = alu_flags;
      `FSRC_ALU_WORD: flags_next = alu_flags;
      `FSRC_LOAD:     flags_next = FLAG_DATA;
      `FSRC_AND:      flags_next = flags_reg & FLAG_DATA;
      `FSRC_OR:       flags_next = flags_reg | FLAG_DATA;
      `FSRC_XOR:      flags_next = flags_reg ^ FLAG_DATA;
      `FSRC_POP:      flags_next = ALU_RESULT[15:8];
      default:        flags_next = flags_reg;
    endcase
    if (EXC_START)
      flags_next[`FLAG_IMASK] = 1'b1;
  end

  // state registers; state, mask bit and instruction address reset, other flags hold
  always @(posedge MCLK) begin
    if (!RST_B) begin
      state_reg              <= ST_IDLE;
      ia_reg                 <= 16'h0000;
      flags_reg[`FLAG_IMASK] <= 1'b1;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      ia_reg    <= ia_next;
      flags_reg <= flags_next;
    end
  end

  assign FLAG_REGISTER  = flags_reg;
  assign FLAG_PUSH_WORD = {flags_reg, flags_reg};
  assign IRQ_MASKED     = flags_reg[`FLAG_IMASK];

  ////////////////////////////////////////////////////////////////////////////
  // flag evaluation and branch decision
  flag_eval u_flag_eval (
    .result      (ALU_RESULT),
    .word_op     (FLAG_SRC == `FSRC_ALU_WORD),
    .half_carry  (ALU_HALF),
    .carry       (ALU_CARRY),
    .overflow    (ALU_OVF),
    .half_en     (ALU_HALF_EN),
    .flags       (flags_reg),
    .cond        (BRANCH_COND),
    .alu_flags   (alu_flags),
    .take_branch (BRANCH_TAKE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bit select and decimal adjust helpers
  assign BIT_VALUE  = BIT_OPERAND[BIT_SEL];
  assign DAA_ADJUST = {((flags_reg[`FLAG_CARRY] || (BIT_OPERAND[7:4] > 4'h9) ||
                        ((BIT_OPERAND[7:4] == 4'h9) && (BIT_OPERAND[3:0] > 4'h9)))
                        ? 4'h6 : 4'h0),
                       ((flags_reg[`FLAG_HALF] || (BIT_OPERAND[3:0] > 4'h9))
                        ? 4'h6 : 4'h0)};
  assign DAS_ADJUST = {(flags_reg[`FLAG_CARRY] ? 4'hA : 4'h0),
                       (flags_reg[`FLAG_HALF] ? 4'hA : 4'h0)};

endmodule

//--- test/vec_source_model.sv
`timescale 1ns/100ps
// far side: answers the reset vector fetch once the register file waits for it
module vec_source_model #(
  parameter logic [15:0] VEC_WORD = 16'h1235
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         busy,
  output logic        vec_valid = 1'b0,
  output logic [15:0] vec_data  = 16'h0000
);
  int wait_cnt = 0;
  // one idle cycle after release, then a one-cycle answer; data inverted when idle
  always @(posedge clk) begin
    vec_valid <= #1 1'b0;
    vec_data  <= #1 ~VEC_WORD;
    wait_cnt  <= (rst_b && busy) ? wait_cnt + 1 : 0;
    if (rst_b && busy && wait_cnt == 1) begin
      vec_valid <= #1 1'b1;
      vec_data  <= #1 VEC_WORD;
    end
  end
endmodule

//--- test/cpu_register_file_asserts.sv
`timescale 1ns/100ps
// timing relations seen at the register file ports
module cpu_register_file_asserts (
  // clock and reset
  input wire        MCLK, RST_B, CLK_EN,
  // single-bit controls and flags
  input wire        VEC_VALID, SP_DEC, SP_INC, ADDR_WORD, EXC_START,
  input wire        RESET_BUSY, IRQ_MASKED, BRANCH_TAKE,
  // buses
  input wire [2:0]  WR_SEL, FLAG_SRC,
  input wire [3:0]  BRANCH_COND,
  input wire [7:0]  FLAG_DATA, FLAG_REGISTER,
  input wire [15:0] VEC_DATA, STACK_POINTER, MEM_ADDR, INSTRUCTION_ADDR,
  input wire [15:0] ALU_RESULT, FLAG_PUSH_WORD
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////////////////
  // vector fetch ends the reset phase with an even address
  sequence s_vec_take; RESET_BUSY && VEC_VALID && CLK_EN; endsequence
  sequence s_vec_done; !RESET_BUSY && !INSTRUCTION_ADDR[0]; endsequence
  AST_VEC_LOAD: assert property (s_vec_take |=> s_vec_done ##0
    INSTRUCTION_ADDR == ($past(VEC_DATA) & 16'hFFFE)) else $error("vector not taken");
  AST_RST_MASK: assert property (disable iff (1'b0) !RST_B && CLK_EN |=> IRQ_MASKED)
    else $error("mask clear in reset");
  AST_IA_EVEN: assert property (!INSTRUCTION_ADDR[0]) else $error("odd fetch address");
  AST_WORD_EVEN: assert property (ADDR_WORD |-> !MEM_ADDR[0])
    else $error("odd word address");
  AST_EXC_MASK: assert property (CLK_EN && EXC_START |=> IRQ_MASKED)
    else $error("mask not set");
  AST_LOAD_PUSH: assert property (CLK_EN && FLAG_SRC == 3'h3 && !EXC_START |=>
    FLAG_PUSH_WORD == {2{$past(FLAG_DATA)}}) else $error("push word wrong");
  AST_XOR: assert property (CLK_EN && FLAG_SRC == 3'h6 && !EXC_START |=>
    FLAG_REGISTER == ($past(FLAG_REGISTER) ^ $past(FLAG_DATA))) else $error("xor wrong");
  AST_ZERO: assert property (CLK_EN && FLAG_SRC == 3'h1 && ALU_RESULT[7:0] == 8'h00 |=>
    FLAG_REGISTER[2] && !FLAG_REGISTER[3]) else $error("zero flag wrong");
  AST_SP_DEC: assert property (CLK_EN && SP_DEC && !SP_INC && WR_SEL != 3'h7 |=>
    STACK_POINTER == $past(STACK_POINTER) - 16'h0002) else $error("stack step wrong");
  AST_BR_EQ: assert property (BRANCH_COND == 4'h7 |-> BRANCH_TAKE == FLAG_REGISTER[2])
    else $error("branch wrong");
endmodule
bind cpu_register_file cpu_register_file_asserts u_chk (.*);

//--- test/cpu_register_file_tb.sv
`timescale 1ns/100ps
// self-checking bench for the cpu register file
module cpu_register_file_tb;
  logic        MCLK = 1'b0, RST_B = 1'b0, CLK_EN = 1'b1, ALU_HALF_EN = 1'b1;
  logic        WR_UPPER_EN = 1'b0, WR_LOWER_EN = 1'b0, SP_DEC = 1'b0, SP_INC = 1'b0;
  logic        ADDR_WORD = 1'b0, IA_LOAD = 1'b0, IA_ADVANCE = 1'b0, EXC_START = 1'b0;
  logic        ALU_HALF = 1'b0, ALU_CARRY = 1'b0, ALU_OVF = 1'b0;
  logic        VEC_VALID, RESET_BUSY, BRANCH_TAKE, BIT_VALUE, IRQ_MASKED;
  logic [2:0]  RD_A_SEL = 3'h0, RD_B_SEL = 3'h0, WR_SEL = 3'h0, ADDR_SEL = 3'h0;
  logic [2:0]  FLAG_SRC = 3'h0, BIT_SEL = 3'h0;
  logic [3:0]  BRANCH_COND = 4'h0;
  logic [7:0]  FLAG_DATA = 8'h00, BIT_OPERAND = 8'h00;
  logic [7:0]  RD_A_UPPER, RD_A_LOWER, FLAG_REGISTER, DAA_ADJUST, DAS_ADJUST, m_flg;
  logic [15:0] WR_DATA = 16'h0000, ADDR_DISP = 16'h0000, IA_DATA = 16'h0000;
  logic [15:0] ALU_RESULT = 16'h0000, VEC_DATA, VEC_ADDR, RD_A_WORD, RD_B_WORD;
  logic [15:0] STACK_POINTER, MEM_ADDR, INSTRUCTION_ADDR, FLAG_PUSH_WORD;
  logic [15:0] m_reg [8];
  int          fail_count = 0, total_checks = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  // design, vector source, clock and hang guard
  cpu_register_file i_dut (.*);
  vec_source_model #(.VEC_WORD(16'h1235)) i_vec (.clk(MCLK), .rst_b(RST_B),
    .busy(RESET_BUSY), .vec_valid(VEC_VALID), .vec_data(VEC_DATA));
  always #5 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      report_and_stop;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc;
    @(posedge MCLK);
    #1;
  endtask
  task report_and_stop;
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // even codes test a condition, odd codes its inverse
  function automatic logic br(input logic [3:0] c, input logic [7:0] f);
    logic nv, b;
    nv = f[3] ^ f[1];
    case (c[3:1])
      0: b = 1'b1;
      1: b = !(f[0] | f[2]);
      2: b = !f[0];
      3: b = !f[2];
      4: b = !f[1];
      5: b = !f[3];
      6: b = !nv;
      default: b = !(f[2] | nv);
    endcase
    return b ^ c[0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int s;
    void'($urandom(9));
    repeat (16) cyc;
    chk(IRQ_MASKED, 1'b1); chk(INSTRUCTION_ADDR, 16'h0000);
    chk(VEC_ADDR, 16'h0000);
    RST_B = 1'b1;
    repeat (20) if (RESET_BUSY === 1'b1) cyc;
    chk(INSTRUCTION_ADDR, 16'h1234);
    IA_ADVANCE = 1'b1; cyc; IA_ADVANCE = 1'b0;
    chk(INSTRUCTION_ADDR, 16'h1236);
    IA_LOAD = 1'b1; IA_DATA = 16'h4321; cyc; IA_LOAD = 1'b0;
    chk(INSTRUCTION_ADDR, 16'h4320);
    CLK_EN = 1'b0; IA_ADVANCE = 1'b1; cyc; CLK_EN = 1'b1; IA_ADVANCE = 1'b0;
    chk(INSTRUCTION_ADDR, 16'h4320);
    for (int i = 0; i < 48; i++) begin
      WR_SEL = (i < 8) ? 3'(7 - i) : 3'($urandom); // stack pointer written first
      WR_UPPER_EN = (i < 8) || $urandom % 2; WR_LOWER_EN = (i < 8) || $urandom % 2;
      WR_DATA = $urandom;
      if (WR_UPPER_EN) m_reg[WR_SEL][15:8] = WR_DATA[15:8];
      if (WR_LOWER_EN) m_reg[WR_SEL][7:0] = WR_DATA[7:0];
      cyc;
      {WR_UPPER_EN, WR_LOWER_EN} = 2'h0;
      {RD_A_SEL, RD_B_SEL, ADDR_SEL, ADDR_WORD} = $urandom; ADDR_DISP = $urandom; #1;
      chk(RD_A_WORD, m_reg[RD_A_SEL]); chk({RD_A_UPPER, RD_A_LOWER}, m_reg[RD_A_SEL]);
      chk(RD_B_WORD, m_reg[RD_B_SEL]);
      chk(MEM_ADDR, (m_reg[ADDR_SEL] + ADDR_DISP) & {15'h7FFF, !ADDR_WORD});
    end
    WR_SEL = 3'h0; SP_DEC = 1'b1; cyc; SP_DEC = 1'b0; m_reg[7] -= 16'h0002;
    chk(STACK_POINTER, m_reg[7]);
    SP_INC = 1'b1; cyc; SP_INC = 1'b0; m_reg[7] += 16'h0002;
    chk(STACK_POINTER, m_reg[7]);
    FLAG_SRC = 3'h3; FLAG_DATA = 8'h00; m_flg = 8'h00; cyc;
    for (int i = 0; i < 64; i++) begin
      s = i % 8; FLAG_SRC = 3'(s); FLAG_DATA = $urandom; EXC_START = ($urandom % 5 == 0);
      ALU_RESULT = ($urandom % 4 == 0) ? 16'h0000 : 16'($urandom);
      {ALU_HALF, ALU_CARRY, ALU_OVF} = $urandom;
      case (s)
        1: m_flg[5:0] = {ALU_HALF, m_flg[4], ALU_RESULT[7], ALU_RESULT[7:0] == 8'h00,
                         ALU_OVF, ALU_CARRY};
        2: m_flg[5:0] = {ALU_HALF, m_flg[4], ALU_RESULT[15], ALU_RESULT == 16'h0000,
                         ALU_OVF, ALU_CARRY};
        3: m_flg = FLAG_DATA;
        4: m_flg &= FLAG_DATA;
        5: m_flg |= FLAG_DATA;
        6: m_flg ^= FLAG_DATA;
        7: m_flg = ALU_RESULT[15:8];
        default: ;
      endcase
      if (EXC_START) m_flg[7] = 1'b1;
      cyc;
      BRANCH_COND = 4'(i); {BIT_OPERAND, BIT_SEL} = $urandom; #1;
      chk(FLAG_REGISTER, m_flg); chk(FLAG_PUSH_WORD, {m_flg, m_flg});
      chk(BRANCH_TAKE, br(BRANCH_COND, m_flg)); chk(IRQ_MASKED, m_flg[7]);
      chk(BIT_VALUE, BIT_OPERAND[BIT_SEL]);
      chk(DAA_ADJUST, {((m_flg[0] || BIT_OPERAND[7:4] > 4'h9 || (BIT_OPERAND[7:4] == 4'h9 &&
        BIT_OPERAND[3:0] > 4'h9)) ? 4'h6 : 4'h0),
        ((m_flg[5] || BIT_OPERAND[3:0] > 4'h9) ? 4'h6 : 4'h0)});
      chk(DAS_ADJUST, {(m_flg[0] ? 4'hA : 4'h0), (m_flg[5] ? 4'hA : 4'h0)});
    end
    report_and_stop;
  end
endmodule
